// *** bench/i2c_eeprom_supervisor_front_tb.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Bench top.
module i2c_eeprom_supervisor_front_tb;
  import eeprom_sup_pkg::*;
  localparam int PROG = 2000;
  localparam int PURST = 300;
  localparam int EXT = 250;
  localparam int WDT = 3000;
  localparam int LIMIT = 40000;
  logic clk, link_clk, rst_n, wp, sup_ok, thr_wr, ext_hi, ext_lo, scl, m_low;
  logic sda_o, sda_oe_n, rst_hi_o, rst_hi_oe_n, rst_lo_n_o, rst_lo_n_oe_n, busy, lock;
  logic sda_w, rst_hi_w, rst_lo_n_w, hi2_oe_n, lo2_oe_n, nowd_hit;
  logic [3:0] a;
  thr_sel_t thr_val, thr_sel;
  int miscompares, check_count, n, dur;
  int cyc = 0;
  time t_busy;

  // Open-drain wires: pull-up on data and low reset, pull-down on high reset.
  assign sda_w = (sda_oe_n ? 1'h1 : sda_o) & ~m_low;
  assign rst_hi_w = (rst_hi_oe_n ? 1'h0 : rst_hi_o) | ext_hi;
  assign rst_lo_n_w = (rst_lo_n_oe_n ? 1'h1 : rst_lo_n_o) & ~ext_lo;

  i2c_host_model #(.H(250)) i_host (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_w));

  i2c_eeprom_supervisor_front #(.PROG_CYC(PROG), .PURST_CYC(PURST), .EXT_CYC(EXT),
    .WDT_CYC(WDT), .GLITCH_CYC(10), .WDT_EN(1'h1)) i_dut (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wp_i(wp), .supply_ok_i(sup_ok),
    .rst_hi_i(rst_hi_w), .rst_hi_o(rst_hi_o), .rst_hi_oe_n(rst_hi_oe_n),
    .rst_lo_n_i(rst_lo_n_w), .rst_lo_n_o(rst_lo_n_o), .rst_lo_n_oe_n(rst_lo_n_oe_n),
    .thr_wr_i(thr_wr), .thr_val_i(thr_val), .thr_sel_o(thr_sel), .prog_busy_o(busy),
    .write_lock_o(lock));

  // Variant without watchdog; it only listens and keeps its own reset wires.
  i2c_eeprom_supervisor_front #(.PROG_CYC(PROG), .PURST_CYC(PURST), .EXT_CYC(EXT),
    .WDT_CYC(WDT), .GLITCH_CYC(10), .WDT_EN(1'h0)) i_nowd (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_n(), .wp_i(wp), .supply_ok_i(sup_ok),
    .rst_hi_i(~hi2_oe_n), .rst_hi_o(), .rst_hi_oe_n(hi2_oe_n),
    .rst_lo_n_i(lo2_oe_n), .rst_lo_n_o(), .rst_lo_n_oe_n(lo2_oe_n),
    .thr_wr_i(thr_wr), .thr_val_i(thr_val), .thr_sel_o(), .prog_busy_o(),
    .write_lock_o());

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge busy) t_busy = $time;
  // A reset of the second instance with its supply good can only be a watchdog.
  always @(negedge hi2_oe_n) if (sup_ok === 1'h1) nowd_hit = 1'h1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // Helpers.
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_thr(input thr_sel_t got, input thr_sel_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_thr

  // Counts falling edges until the chosen output reaches lvl, at most lim.
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int k);
    k = 0;
    while ((sel == 1 ? busy : rst_hi_oe_n) !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_sig

  task automatic xfer(input logic [7:0] dev, input int nb, output logic [3:0] acks);
    logic [31:0] w;
    logic ack;
    w = {dev, 8'h01, 8'h20, 8'h5A};
    acks = 4'h0;
    i_host.start_cond();
    for (int i = 0; i < nb; i++) begin
      i_host.send_byte(w[31 - 8 * i -: 8], ack);
      acks[i] = ack;
    end
    i_host.stop_cond();
    @(negedge clk);
  endtask : xfer

  task automatic set_thr(input thr_sel_t v, input thr_sel_t exp);
    thr_val = v;
    thr_wr = 1'h1;
    @(negedge clk);
    thr_wr = 1'h0;
    repeat (2) @(negedge clk);
    chk_thr(thr_sel, exp);
  endtask : set_thr

  // ==========================================================================
  // Scenarios.
  task automatic t_power();
    repeat (20) @(negedge clk);
    chk_bit(rst_hi_oe_n, 1'h0);
    chk_bit(lock, 1'h1);
    rst_n = 1'h1;
    repeat (50) @(negedge clk);
    chk_bit(rst_lo_n_oe_n, 1'h0);
    sup_ok = 1'h1;
    wait_sig(0, 1'h1, PURST + 40, n);
    chk_bit(n >= PURST && n <= PURST + 10, 1'h1);
    chk_bit(rst_hi_w, 1'h0);
    chk_bit(rst_lo_n_w, 1'h1);
    chk_bit(lock, 1'h0);
    repeat (20) @(negedge clk);
  endtask : t_power

  task automatic t_bus();
    xfer(8'hA0, 4, a);
    chk_bit(a === 4'hF, 1'h1);
    wait_sig(1, 1'h1, 50, n);
    chk_bit(busy, 1'h1);
    xfer(8'hA0, 1, a);
    chk_bit(a[0], 1'h0);
    wait_sig(1, 1'h0, PROG, n);
    dur = int'(($time - t_busy) / 10);
    chk_bit(dur >= PROG - 3 && dur <= PROG + 3, 1'h1);
    xfer(8'hA1, 1, a);
    chk_bit(a[0], 1'h1);
    xfer(8'hB0, 1, a);
    chk_bit(a[0], 1'h0);
    xfer(8'hAE, 1, a);
    chk_bit(a[0], 1'h1);
    wait_sig(1, 1'h0, PROG + 50, n);
    wp = 1'h1;
    xfer(8'hA0, 4, a);
    wp = 1'h0;
    chk_bit(a === 4'h7, 1'h1);
    wait_sig(1, 1'h1, 50, n);
    chk_bit(busy, 1'h0);
  endtask : t_bus

  task automatic t_supply();
    sup_ok = 1'h0;
    wait_sig(0, 1'h0, 20, n);
    chk_bit(n <= 8, 1'h1);
    chk_bit(rst_hi_w, 1'h1);
    chk_bit(rst_lo_n_w, 1'h0);
    chk_bit(lock, 1'h1);
    xfer(8'hA0, 4, a);
    chk_bit(a === 4'h7, 1'h1);
    wait_sig(1, 1'h1, 50, n);
    chk_bit(busy, 1'h0);
    sup_ok = 1'h1;
    wait_sig(0, 1'h1, PURST + 40, n);
    chk_bit(n >= PURST && n <= PURST + 10, 1'h1);
    chk_thr(thr_sel, 3'h4);
  endtask : t_supply

  task automatic t_ext();
    for (int p = 0; p < 2; p++) begin
      ext_hi = p[0];
      ext_lo = ~p[0];
      repeat (5) @(negedge clk);
      ext_hi = 1'h0;
      ext_lo = 1'h0;
      wait_sig(0, 1'h0, 40, n);
      chk_bit(n == 40, 1'h1);
      ext_hi = p[0];
      ext_lo = ~p[0];
      wait_sig(0, 1'h0, 30, n);
      chk_bit(n >= 10 && n <= 20, 1'h1);
      ext_hi = 1'h0;
      ext_lo = 1'h0;
      wait_sig(0, 1'h1, EXT + 40, n);
      chk_bit(n >= EXT - 5 && n <= EXT + 10, 1'h1);
    end
  endtask : t_ext

  task automatic t_wdog();
    wait_sig(0, 1'h0, WDT + 40, n);
    chk_bit(n >= WDT - 20 && n <= WDT + 30, 1'h1);
    wait_sig(0, 1'h1, EXT + 40, n);
    chk_bit(n >= EXT - 5 && n <= EXT + 10, 1'h1);
    repeat (5) begin
      wait_sig(0, 1'h0, 1000, n);
      chk_bit(n == 1000, 1'h1);
      i_host.start_cond();
      i_host.stop_cond();
      @(negedge clk);
    end
    chk_bit(nowd_hit, 1'h0);
  endtask : t_wdog

  initial begin
    rst_n = 1'h0;
    wp = 1'h0;
    sup_ok = 1'h0;
    thr_wr = 1'h0;
    thr_val = 3'h0;
    ext_hi = 1'h0;
    ext_lo = 1'h0;
    nowd_hit = 1'h0;
    t_power();
    set_thr(3'h3, 3'h3);
    set_thr(3'h6, 3'h3);
    set_thr(3'h4, 3'h4);
    t_bus();
    t_supply();
    t_ext();
    t_wdog();
    finish_test();
  end
endmodule : i2c_eeprom_supervisor_front_tb

// *** bench/i2c_host_model.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Bus master model.
// The serial clock stands high outside frames, as a real master leaves it.
module i2c_host_model #(
  parameter int H = 250 // High time of the serial clock in ns; the low time is 1.5 times this.
) (
  output logic scl_o, // Serial clock.
  output logic sda_low_o, // High pulls the data line low.
  input wire logic sda_i // Resolved data line.
);
  initial begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
  end

  task automatic start_cond();
    #(H);
    sda_low_o = 1'h1;
    #(H);
    scl_o = 1'h0;
    #(H / 2);
  endtask : start_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      #(H);
      scl_o = 1'h1;
      #(H);
      scl_o = 1'h0;
      #(H / 2);
    end
    sda_low_o = 1'h0;
    #(H);
    scl_o = 1'h1;
    #(H / 2);
    ack = ~sda_i;
    #(H / 2);
    scl_o = 1'h0;
    #(H / 2);
  endtask : send_byte

  task automatic stop_cond();
    sda_low_o = 1'h1;
    #(H);
    scl_o = 1'h1;
    #(H);
    sda_low_o = 1'h0;
    #(H);
  endtask : stop_cond
endmodule : i2c_host_model

// *** verilog/eeprom_sup_map.svh ***
`ifndef EEPROM_SUP_MAP_SVH
`define EEPROM_SUP_MAP_SVH

// ==========================================================================
// Clock and timing
`define CLK_PERIOD_NS 10
`define PROG_TIME_MS 10
`define PROG_CYC (`PROG_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define PURST_TIME_MS 200
`define PURST_CYC (`PURST_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define EXT_STRETCH_MS 200
`define EXT_STRETCH_CYC (`EXT_STRETCH_MS * 1000000 / `CLK_PERIOD_NS)
`define WDT_TIMEOUT_MS 1600
`define WDT_CYC (`WDT_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define GLITCH_NS 100
`define GLITCH_CYC ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define THRESHOLD_TO_RESET_DELAY_US 5
`define THRESHOLD_TO_RESET_DELAY_CYC (`THRESHOLD_TO_RESET_DELAY_US * 1000 / `CLK_PERIOD_NS)

// ==========================================================================
// Bus protocol fields
`define SLAVE_TYPE 4'hA
`define ADDR_BYTES 2'h2
`define BIT_ACK 4'h8

// ==========================================================================
// Threshold selection
`define THR_DEFAULT 3'h0
`define THR_OPTIONS 3'h5

`endif

// *** verilog/eeprom_sup_pkg.sv ***
package eeprom_sup_pkg;
  typedef logic [2:0] thr_sel_t;
  typedef enum logic [1:0] {RS_LOW, RS_HOLD, RS_IDLE} rst_state_t;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_DATA, L_ACK, L_WAIT} link_state_t;
endpackage : eeprom_sup_pkg

// *** verilog/i2c_eeprom_supervisor_front.sv ***
`timescale 1ns/100ps
`include "eeprom_sup_map.svh"
// Overview of operation
// R1 - Host waits the power-up delay after supply is stable before any transfer.
// R2 - After a write stop, program cycle runs; slave address is not acknowledged.
// R3 - Reset pin pulses shorter than the glitch width never start a reset.
// R4 - Reset outputs held active below threshold, then for the power-up timeout.
// R5 - After the power-up timeout both open-drain reset outputs are released.
// R6 - Supply falling below threshold drives both resets active within 5 us.
// R7 - Active level on either reset pin starts a reset stretch of about 200 ms.
// R8 - With watchdog, no data-line transition for 1.6 s forces a reset.
// R9 - Every rising or falling data-line transition clears the watchdog counter.
// R10 - While any reset is asserted the watchdog counter stays cleared.
// R11 - A build option removes the watchdog; inactivity then never resets.
// R12 - Write-protect high makes the array read-only; low allows writes.
// R13 - Writes are inhibited while the supply is below the reset threshold.
// R14 - Selected threshold option is held until reprogrammed externally.
// R15 - Start is data falling with clock high; nothing counts before a start.
// R16 - Stop is data rising with clock high and ends every operation.
// R17 - Any data change while the clock is high is taken as start or stop.
// R18 - Address upper nibble must be 1010, three bits ignored, last is direction.
// R19 - After start and matching address the device acknowledges, then proceeds.
// R20 - The master starts a new transfer only while the bus is idle.
// R21 - A receiver acknowledges each byte by pulling data low in clock nine.
// R22 - When protected, address bytes are acked, first data byte is not.
// R23 - All long intervals come from the free-running clock via parameters.
module i2c_eeprom_supervisor_front #(
  parameter int PROG_CYC = `PROG_CYC, // Program cycle length.
  parameter int PURST_CYC = `PURST_CYC, // Power-up reset timeout.
  parameter int EXT_CYC = `EXT_STRETCH_CYC, // External or watchdog reset stretch.
  parameter int WDT_CYC = `WDT_CYC, // Watchdog timeout.
  parameter int GLITCH_CYC = `GLITCH_CYC, // Reset pin filter length.
  parameter bit WDT_EN = 1'b1 // Watchdog variant.
) (
  input wire logic clk, // Internal oscillator.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic link_clk, // Bus sampling clock.
  input wire logic scl_i, // Serial clock pin.
  input wire logic sda_i, // Serial data pin level.
  output logic sda_o, // Serial data drive value.
  output logic sda_oe_n, // Serial data enable, low drives.
  input wire logic wp_i, // Write protect pin.
  input wire logic supply_ok_i, // Supply above trip threshold.
  input wire logic rst_hi_i, // Active-high reset pin level.
  output logic rst_hi_o, // Active-high reset drive value.
  output logic rst_hi_oe_n, // Active-high reset enable, low drives.
  input wire logic rst_lo_n_i, // Active-low reset pin level.
  output logic rst_lo_n_o, // Active-low reset drive value.
  output logic rst_lo_n_oe_n, // Active-low reset enable, low drives.
  input wire logic thr_wr_i, // Threshold programming strobe.
  input wire eeprom_sup_pkg::thr_sel_t thr_val_i, // Threshold option to store.
  output eeprom_sup_pkg::thr_sel_t thr_sel_o, // Stored threshold option.
  output logic prog_busy_o, // Program cycle running.
  output logic write_lock_o // Writes inhibited by supply.
);
  import eeprom_sup_pkg::*;

  // ========================================================================
  // Internal clock domain: synchronisers
  logic sup_s1, sup_s, rhi_s1, rhi_s, rlo_s1, rlo_s;
  logic [2:0] wr_sync_q, wd_sync_q;
  logic wr_tgl_q, wd_tgl_q, busy_q, lock_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sup_s1 <= 1'b0;
      sup_s <= 1'b0;
      rhi_s1 <= 1'b0;
      rhi_s <= 1'b0;
      rlo_s1 <= 1'b1;
      rlo_s <= 1'b1;
      wr_sync_q <= 3'h0;
      wd_sync_q <= 3'h0;
    end else begin
      sup_s1 <= supply_ok_i;
      sup_s <= sup_s1;
      rhi_s1 <= rst_hi_i;
      rhi_s <= rhi_s1;
      rlo_s1 <= rst_lo_n_i;
      rlo_s <= rlo_s1;
      wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
      wd_sync_q <= {wd_sync_q[1:0], wd_tgl_q};
    end
  end

  logic wr_evt, wd_evt;
  assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
  assign wd_evt = wd_sync_q[2] ^ wd_sync_q[1];

  // ========================================================================
  // Reset pin filter
  // The pins read back our own drive, so they are blanked while driving and
  // for the synchroniser depth afterwards; otherwise a reset would retrigger.
  logic drive_q;
  logic [2:0] drv_hist_q;
  logic [7:0] gl_cnt_q;
  logic ext_act, ext_fire;
  assign ext_act = (rhi_s | ~rlo_s) & ~drive_q & ~(|drv_hist_q);
  // R3 glitch width filter
  assign ext_fire = ext_act && (gl_cnt_q == 8'(GLITCH_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_hist_q <= 3'h7;
      gl_cnt_q <= 8'h00;
    end else begin
      drv_hist_q <= {drv_hist_q[1:0], drive_q};
      if (!ext_act) begin
        gl_cnt_q <= 8'h00;
      end else if (!ext_fire) begin
        gl_cnt_q <= gl_cnt_q + 8'h01;
      end
    end
  end

  // ========================================================================
  // Reset sequencer
  rst_state_t rs_q;
  // R23 parameter cycle counts
  logic [31:0] hold_cnt_q, hold_len_q, wdt_cnt_q;
  logic wdt_fire;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs_q <= RS_LOW;
      hold_cnt_q <= 32'h0;
      hold_len_q <= 32'(PURST_CYC);
    end else if (!sup_s) begin
      // R6 trip on low supply
      rs_q <= RS_LOW;
      hold_cnt_q <= 32'h0;
    end else begin
      case (rs_q)
        RS_LOW: begin
          // R4 power-up timeout start
          rs_q <= RS_HOLD;
          hold_cnt_q <= 32'h0;
          hold_len_q <= 32'(PURST_CYC);
        end
        RS_HOLD: begin
          // R5 release at timeout end
          if (hold_cnt_q == hold_len_q - 32'h1) begin
            rs_q <= RS_IDLE;
          end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
          end
        end
        RS_IDLE: begin
          // R7 external reset stretch
          if (ext_fire || wdt_fire) begin
            rs_q <= RS_HOLD;
            hold_cnt_q <= 32'h0;
            hold_len_q <= 32'(EXT_CYC);
          end
        end
        default: begin
          rs_q <= RS_LOW;
        end
      endcase
    end
  end

  // R4 open-drain reset drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_q <= 1'b1;
      rst_hi_oe_n <= 1'b0;
      rst_lo_n_oe_n <= 1'b0;
      rst_hi_o <= 1'b1;
      rst_lo_n_o <= 1'b0;
    end else begin
      drive_q <= rs_q != RS_IDLE;
      rst_hi_oe_n <= rs_q == RS_IDLE;
      rst_lo_n_oe_n <= rs_q == RS_IDLE;
      rst_hi_o <= 1'b1;
      rst_lo_n_o <= 1'b0;
    end
  end

  // ========================================================================
  // Watchdog
  // R8 inactivity timeout
  assign wdt_fire = WDT_EN && (rs_q == RS_IDLE) && (wdt_cnt_q == 32'(WDT_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_cnt_q <= 32'h0;
    end else if (!WDT_EN || rs_q != RS_IDLE || wd_evt) begin
      // R9 R10 R11 clear and hold
      wdt_cnt_q <= 32'h0;
    end else if (!wdt_fire) begin
      wdt_cnt_q <= wdt_cnt_q + 32'h1;
    end
  end

  // ========================================================================
  // Program cycle, supply lock-out and threshold store
  logic [31:0] prog_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      prog_cnt_q <= 32'h0;
    end else if (wr_evt && !lock_q) begin
      // R2 program cycle start
      busy_q <= 1'b1;
      prog_cnt_q <= 32'h0;
    end else if (busy_q) begin
      if (prog_cnt_q == 32'(PROG_CYC - 1)) begin
        busy_q <= 1'b0;
      end else begin
        prog_cnt_q <= prog_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_q <= 1'b1;
      prog_busy_o <= 1'b0;
      write_lock_o <= 1'b1;
      thr_sel_o <= `THR_DEFAULT;
    end else begin
      // R13 supply lock-out
      lock_q <= !sup_s;
      write_lock_o <= !sup_s;
      prog_busy_o <= busy_q;
      // R14 threshold hold
      if (thr_wr_i && thr_val_i < `THR_OPTIONS) begin
        thr_sel_o <= thr_val_i;
      end
    end
  end

  // ========================================================================
  // Link clock domain: synchronisers
  logic lrst_s1, lrst_n, scl_s1, scl_s, sda_s1, sda_s, scl_p, sda_p;
  logic busy_s1, busy_s, lock_s1, lock_s, wp_s1, wp_s;

  always_ff @(posedge link_clk) begin
    lrst_s1 <= rst_n;
    lrst_n <= lrst_s1;
    scl_s1 <= scl_i;
    scl_s <= scl_s1;
    scl_p <= scl_s;
    sda_s1 <= sda_i;
    sda_s <= sda_s1;
    sda_p <= sda_s;
    busy_s1 <= busy_q;
    busy_s <= busy_s1;
    lock_s1 <= lock_q;
    lock_s <= lock_s1;
    wp_s1 <= wp_i;
    wp_s <= wp_s1;
  end

  // ========================================================================
  // Bus protocol engine
  logic start_ev, stop_ev, scl_rise, scl_fall;
  // R17 data change with clock high
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;

  link_state_t ls_q;
  logic [7:0] sh_q;
  logic [3:0] bcnt_q;
  logic [1:0] idx_q;
  logic nack_q, rd_q, wr_ok_q;
  logic addr_hit, data_byte, ack_ok;

  // R18 address match
  assign addr_hit = (sh_q[7:4] == `SLAVE_TYPE) && !busy_s;
  assign data_byte = (ls_q == L_DATA) && (idx_q == `ADDR_BYTES);
  // R12 R22 protected data nack
  assign ack_ok = (ls_q == L_ADDR) ? addr_hit : (data_byte ? !(wp_s || lock_s) : 1'b1);

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      ls_q <= L_IDLE;
      sh_q <= 8'h00;
      bcnt_q <= 4'h0;
      idx_q <= 2'h0;
      nack_q <= 1'b0;
      rd_q <= 1'b0;
      wr_ok_q <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (start_ev) begin
      // R15 start detection
      ls_q <= L_ADDR;
      bcnt_q <= 4'h0;
      idx_q <= 2'h0;
      wr_ok_q <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop_ev) begin
      // R16 stop ends the operation
      ls_q <= L_IDLE;
      wr_ok_q <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      case (ls_q)
        L_ADDR, L_DATA: begin
          if (scl_rise && bcnt_q != `BIT_ACK) begin
            sh_q <= {sh_q[6:0], sda_s};
            bcnt_q <= bcnt_q + 4'h1;
          end else if (scl_fall && bcnt_q == `BIT_ACK) begin
            // R19 R21 acknowledge in clock nine
            sda_oe_n <= !ack_ok;
            nack_q <= !ack_ok;
            ls_q <= L_ACK;
            if (ls_q == L_ADDR) begin
              rd_q <= sh_q[0];
            end
            if (data_byte && ack_ok) begin
              wr_ok_q <= 1'b1;
            end
            if (ls_q == L_DATA && idx_q != `ADDR_BYTES) begin
              idx_q <= idx_q + 2'h1;
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            bcnt_q <= 4'h0;
            ls_q <= (nack_q || rd_q) ? L_WAIT : L_DATA;
          end
        end
        default: begin
          ls_q <= ls_q;
        end
      endcase
    end
  end

  // Read data is not sourced here, so a read leaves the line released.
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      wr_tgl_q <= 1'b0;
      wd_tgl_q <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      // R2 write stop starts programming
      if (stop_ev && wr_ok_q) begin
        wr_tgl_q <= ~wr_tgl_q;
      end
      // R9 data transition event
      if (sda_s != sda_p) begin
        wd_tgl_q <= ~wd_tgl_q;
      end
    end
  end

  // ========================================================================
  // Assertions
  supply_trip_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    !sup_s |-> ##[1:2] (!rst_hi_oe_n && !rst_lo_n_oe_n))
    else $error("reset not driven after supply drop");
  hold_early_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (rs_q == RS_HOLD && hold_cnt_q < hold_len_q - 32'h1 && sup_s) |=> rs_q == RS_HOLD)
    else $error("reset hold ended early");
  hold_release_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (rs_q == RS_HOLD && hold_cnt_q == hold_len_q - 32'h1 && sup_s && !ext_act)
    |=> ##1 (rst_hi_oe_n && rst_lo_n_oe_n))
    else $error("reset outputs not released at timeout");
  glitch_reject_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    $rose(ext_act) |-> !ext_fire [*8])
    else $error("short reset pulse accepted");
  ext_start_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    (ext_fire && rs_q == RS_IDLE && sup_s) |=> (rs_q == RS_HOLD && hold_len_q == 32'(EXT_CYC)))
    else $error("external reset not stretched");
  wdt_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    wd_evt |=> wdt_cnt_q == 32'h0)
    else $error("watchdog not cleared by data edge");
  wdt_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (rs_q != RS_IDLE) |=> wdt_cnt_q == 32'h0)
    else $error("watchdog counting during reset");
  wdt_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    (!WDT_EN && rs_q == RS_IDLE && sup_s && !ext_fire) |=> rs_q == RS_IDLE)
    else $error("watchdog fired in variant without it");
  prog_len_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (busy_q && prog_cnt_q == 32'(PROG_CYC - 1) && !wr_evt) |=> !busy_q)
    else $error("program cycle overran");
  thr_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    !thr_wr_i |=> $stable(thr_sel_o))
    else $error("threshold changed without programming");
  busy_nack_a: assert property (@(posedge link_clk) disable iff (!lrst_n) // R2
    (ls_q == L_ADDR && scl_fall && bcnt_q == `BIT_ACK && busy_s && !start_ev && !stop_ev)
    |=> sda_oe_n)
    else $error("address acknowledged while programming");
  addr_ack_a: assert property (@(posedge link_clk) disable iff (!lrst_n) // R19
    (ls_q == L_ADDR && scl_fall && bcnt_q == `BIT_ACK && addr_hit && !start_ev && !stop_ev)
    |=> (!sda_oe_n && ls_q == L_ACK))
    else $error("matching address not acknowledged");
  prot_nack_a: assert property (@(posedge link_clk) disable iff (!lrst_n) // R22
    (data_byte && scl_fall && bcnt_q == `BIT_ACK && (wp_s || lock_s) && !start_ev && !stop_ev)
    |=> (sda_oe_n && !wr_ok_q))
    else $error("protected data byte acknowledged");
  start_seen_a: assert property (@(posedge link_clk) disable iff (!lrst_n) // R15
    start_ev |=> (ls_q == L_ADDR && bcnt_q == 4'h0))
    else $error("start not detected");
  stop_seen_a: assert property (@(posedge link_clk) disable iff (!lrst_n) // R16
    stop_ev |=> (ls_q == L_IDLE && sda_oe_n))
    else $error("stop not detected");

  powerup_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    rs_q == RS_HOLD ##1 rs_q == RS_IDLE);
  wdt_reset_c: cover property (@(posedge clk) disable iff (!rst_n) wdt_fire);
  prog_run_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(busy_q));
  addr_ack_c: cover property (@(posedge link_clk) disable iff (!lrst_n)
    ls_q == L_ACK && !sda_oe_n);
endmodule : i2c_eeprom_supervisor_front
